// ---- dv/ssc_top_sva.sv ----
/*
  Checker for the status and control flag block: bus timing, status
  word contents and the control outputs after a control write.
  Assumes the bind below and the top module's port names.
*/
`timescale 1ns/1ps
module ssc_top_sva #(
  parameter longint unsigned HALF_PERIOD_CYC = ssc_pkg::HALF_PERIOD_CYC
)
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ssc_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [ssc_pkg::DATA_W-1:0] PWDATA_I,
  input wire logic [ssc_pkg::DATA_W-1:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic RTC_DATA_ERR_I,
  input wire logic SUMMER_TIME_I,
  input wire logic FB_COMM_ERR_I,
  input wire logic FB_POWER_ERR_I,
  input wire logic MENU_LIGHT_ON_I,
  input wire logic FB_DISCONNECT_O,
  input wire logic BACKLIGHT_ON_O,
  input wire logic DISPLAY_FROM_MANAGER_O
);
  // ********************************************************
  // Bus phases
  // ********************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_done;
    PSEL_I && PENABLE_I && PREADY_O;
  endsequence
  sequence s_ctrl_wr;
    s_done ##0 (PWRITE_I && PADDR_I == ssc_pkg::OFS_CONTROL);
  endsequence
  sequence s_stat_rd;
    s_done ##0 (!PWRITE_I && PADDR_I == ssc_pkg::OFS_STATUS);
  endsequence

  // ********************************************************
  // Properties
  // ********************************************************
  // Exactly one wait state, and the answer lasts one cycle
  property p_wait;
    PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O ##1 !PREADY_O;
  endproperty
  property p_idle;
    !PREADY_O |-> PRDATA_O == 32'h0000_0000;
  endproperty
  property p_unmapped;
    s_done ##0 (PADDR_I > ssc_pkg::OFS_SCAN) |-> PSLVERR_O && PRDATA_O == 32'h0000_0000;
  endproperty
  property p_const;
    s_stat_rd |-> PRDATA_O[1:0] == 2'h1 && PRDATA_O[13] == 1'b0;
  endproperty
  property p_init;
    s_stat_rd |-> PRDATA_O[7] != PRDATA_O[8];
  endproperty
  // Status register lags its inputs by one edge, read data by one more
  property p_levels;
    s_stat_rd |-> PRDATA_O[6:3] ==
      $past({FB_POWER_ERR_I, FB_COMM_ERR_I, SUMMER_TIME_I, RTC_DATA_ERR_I}, 2);
  endproperty
  property p_fb;
    s_ctrl_wr |-> ##2 FB_DISCONNECT_O == $past(PWDATA_I[0], 2);
  endproperty
  property p_disp;
    s_ctrl_wr |-> ##2 DISPLAY_FROM_MANAGER_O == $past(PWDATA_I[3], 2);
  endproperty
  // Force beats inhibit; with neither, the menu request decides
  property p_light;
    s_ctrl_wr |-> ##2 BACKLIGHT_ON_O == ($past(PWDATA_I[2], 2) ||
      (!$past(PWDATA_I[1], 2) && $past(MENU_LIGHT_ON_I, 1)));
  endproperty

  a_wait: assert property (p_wait) else $error("ready not after one wait state");
  a_idle: assert property (p_idle) else $error("read data not idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_const: assert property (p_const) else $error("constant flags wrong");
  a_init: assert property (p_init) else $error("initial flags not complementary");
  a_levels: assert property (p_levels) else $error("level flags wrong");
  a_fb: assert property (p_fb) else $error("fieldbus control wrong");
  a_disp: assert property (p_disp) else $error("display source wrong");
  a_light: assert property (p_light) else $error("backlight wrong");
endmodule : ssc_top_sva

bind ssc_top ssc_top_sva #(.HALF_PERIOD_CYC(HALF_PERIOD_CYC)) ssc_top_sva_inst
(
  .CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .RTC_DATA_ERR_I(RTC_DATA_ERR_I),
  .SUMMER_TIME_I(SUMMER_TIME_I), .FB_COMM_ERR_I(FB_COMM_ERR_I),
  .FB_POWER_ERR_I(FB_POWER_ERR_I), .MENU_LIGHT_ON_I(MENU_LIGHT_ON_I),
  .FB_DISCONNECT_O(FB_DISCONNECT_O), .BACKLIGHT_ON_O(BACKLIGHT_ON_O),
  .DISPLAY_FROM_MANAGER_O(DISPLAY_FROM_MANAGER_O)
);

// ---- dv/test_system_status_control_bits.sv ----
/*
  Self-checking bench for the status and control flag block.
  Drives APB and every condition input itself; short square period.
*/
`timescale 1ns/1ps
module test_system_status_control_bits;
  localparam longint unsigned HALF = 16;
  logic CLK_I = 1'b0, RST_I = 1'b1, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
  logic [ssc_pkg::ADDR_W-1:0] PADDR_I = '0;
  logic [31:0] PWDATA_I = '0, PRDATA_O, rdat;
  logic PREADY_O, PSLVERR_O, serr, FB_DISCONNECT_O, BACKLIGHT_ON_O, DISPLAY_FROM_MANAGER_O;
  logic RUN_MODE_I = 0, RTC_DATA_ERR_I = 0, SUMMER_TIME_I = 0, FB_COMM_ERR_I = 0;
  logic FB_POWER_ERR_I = 0, TS_DECODING_I = 0, TS_DONE_I = 0, TS_ERR_I = 0;
  logic MODEM_DCD_I = 0, CELL_REG_I = 0, CONV_SUPPLY_I = 0, MENU_LIGHT_ON_I = 0;
  logic [7:0] ANALOG_WIRE_BREAK_I = '0, ANALOG_RANGE_ERR_I = '0;
  int num_errors = 0, samples_checked = 0;
  longint unsigned cyc = 0, stamp, rel, t;
  int unsigned pos [8] = '{ssc_pkg::ST_CALENDAR_FAULT, ssc_pkg::ST_DAYLIGHT,
    ssc_pkg::ST_FB_COMM_FAULT, ssc_pkg::ST_FB_POWER_FAULT, ssc_pkg::ST_TS_DECODING,
    ssc_pkg::ST_MODEM_CARRIER, ssc_pkg::ST_CELL_REG, ssc_pkg::ST_CONV_SUPPLY};

  ssc_top #(.HALF_PERIOD_CYC(HALF)) ssc_top_inst
  (
    .CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .RUN_MODE_I(RUN_MODE_I),
    .RTC_DATA_ERR_I(RTC_DATA_ERR_I), .SUMMER_TIME_I(SUMMER_TIME_I),
    .FB_COMM_ERR_I(FB_COMM_ERR_I), .FB_POWER_ERR_I(FB_POWER_ERR_I),
    .TS_DECODING_I(TS_DECODING_I), .TS_DONE_I(TS_DONE_I), .TS_ERR_I(TS_ERR_I),
    .MODEM_DCD_I(MODEM_DCD_I), .CELL_REG_I(CELL_REG_I), .CONV_SUPPLY_I(CONV_SUPPLY_I),
    .ANALOG_WIRE_BREAK_I(ANALOG_WIRE_BREAK_I), .ANALOG_RANGE_ERR_I(ANALOG_RANGE_ERR_I),
    .MENU_LIGHT_ON_I(MENU_LIGHT_ON_I), .FB_DISCONNECT_O(FB_DISCONNECT_O),
    .BACKLIGHT_ON_O(BACKLIGHT_ON_O), .DISPLAY_FROM_MANAGER_O(DISPLAY_FROM_MANAGER_O)
  );

  // ********************************************************
  // Clock, cycle count and watchdog
  // ********************************************************
  initial forever #4 CLK_I = ~CLK_I;
  always @(posedge CLK_I) cyc <= cyc + 1;
  // Whole run is well under a thousand cycles; this leaves a wide margin
  initial
  begin
    repeat (20000) @(posedge CLK_I);
    num_errors++;
    complete_run();
  end

  // ********************************************************
  // Tasks
  // ********************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Ready, read data and error are taken at the rising edge that completes;
  // the slave's flops change after that edge, so the pre-edge values are read
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge CLK_I);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    do
    begin
      @(posedge CLK_I);
      n++;
    end
    while (PREADY_O !== 1'b1 && n < 16);
    if (n >= 16)
      num_errors++;
    rdat = PRDATA_O;
    serr = PSLVERR_O;
    stamp = cyc;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic scan();
    apb(1'b1, ssc_pkg::OFS_SCAN, 32'h0000_0001);
  endtask : scan

  // Drive one pattern on all level inputs and compare the status word
  task automatic levels(input logic [7:0] l, input logic [7:0] w, input logic [7:0] r);
    logic [31:0] e;
    e = 32'h0000_0101;
    for (int i = 0; i < 8; i++)
      e[pos[i]] = l[i];
    e[ssc_pkg::ST_ANALOG_BASE +: 8] = w | r;
    {CONV_SUPPLY_I, CELL_REG_I, MODEM_DCD_I, TS_DECODING_I, FB_POWER_ERR_I,
      FB_COMM_ERR_I, SUMMER_TIME_I, RTC_DATA_ERR_I} <= l;
    ANALOG_WIRE_BREAK_I <= w;
    ANALOG_RANGE_ERR_I <= r;
    @(posedge CLK_I);
    rd(ssc_pkg::OFS_STATUS);
    check("status", rdat & ~32'h4, e);
  endtask : levels

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  // ********************************************************
  // Test sequence
  // ********************************************************
  initial
  begin
    repeat (5) @(posedge CLK_I);
    RST_I <= 1'b0;
    rel = cyc;
    // Square wave sampled away from its edges, since read latency is loose
    repeat (24)
    begin
      rd(ssc_pkg::OFS_STATUS);
      t = stamp - rel;
      if (t % HALF > 3 && t % HALF < HALF - 2)
        check("square", {31'h0, rdat[2]}, {31'h0, (t / HALF) % 2 == 0});
    end
    levels(8'ha5, 8'h0f, 8'h30);
    levels(8'h5a, 8'h00, 8'hc0);
    levels(8'h00, 8'h00, 8'h00);
    // Every control setting against both menu requests
    for (int v = 0; v < 32; v++)
    begin
      MENU_LIGHT_ON_I <= v[4];
      apb(1'b1, ssc_pkg::OFS_CONTROL, 32'hffff_fff0 | v[3:0]);
      rd(ssc_pkg::OFS_CONTROL);
      check("control", rdat, {28'h0, v[3:0]});
      check("fb_disc", {31'h0, FB_DISCONNECT_O}, {31'h0, v[0]});
      check("display", {31'h0, DISPLAY_FROM_MANAGER_O}, {31'h0, v[3]});
      check("light", {31'h0, BACKLIGHT_ON_O}, {31'h0, v[2] | (~v[1] & v[4])});
    end
    // Read-only status and unmapped places
    apb(1'b1, ssc_pkg::OFS_STATUS, 32'h0000_0000);
    check("ro_err", {31'h0, serr}, 32'h0);
    rd(ssc_pkg::OFS_STATUS);
    check("ro_const", rdat & 32'h3, 32'h1);
    apb(1'b1, 12'h010, 32'h0000_0000);
    check("bad_wr", {31'h0, serr}, 32'h1);
    rd(ssc_pkg::OFS_CONTROL);
    check("ctrl_kept", rdat, 32'h0000_000f);
    rd(12'h00c);
    check("bad_rd", {serr, rdat[30:0]}, 32'h8000_0000);
    // Two stop-to-run changes, each shown for exactly one scan
    repeat (2)
    begin
      RUN_MODE_I <= 1'b0;
      @(posedge CLK_I);
      RUN_MODE_I <= 1'b1;
      @(posedge CLK_I);
      rd(ssc_pkg::OFS_STATUS);
      check("init_arm", {30'h0, rdat[8:7]}, 32'h2);
      scan();
      rd(ssc_pkg::OFS_STATUS);
      check("init_on", {30'h0, rdat[8:7]}, 32'h1);
      rd(ssc_pkg::OFS_STATUS);
      check("init_hold", {30'h0, rdat[8:7]}, 32'h1);
      scan();
      rd(ssc_pkg::OFS_STATUS);
      check("init_off", {30'h0, rdat[8:7]}, 32'h2);
    end
    // Clean, failed, clean decode: failure holds until the next clean one
    for (int k = 0; k < 3; k++)
    begin
      TS_ERR_I <= (k == 1);
      TS_DONE_I <= 1'b1;
      @(posedge CLK_I);
      TS_DONE_I <= 1'b0;
      TS_ERR_I <= 1'b0;
      scan();
      rd(ssc_pkg::OFS_STATUS);
      check("ts_end", {30'h0, rdat[14], rdat[10]}, {30'h0, k == 1, k != 1});
      scan();
      rd(ssc_pkg::OFS_STATUS);
      check("ts_next", {30'h0, rdat[14], rdat[10]}, {30'h0, k == 1, 1'b0});
    end
    complete_run();
  end
endmodule : test_system_status_control_bits

// ---- rtl/ssc_half_sec.sv ----
/*
  Free-running square wave, high then low for one half period each.
  Assumes a synchronous active-high reset on the controller clock.
*/
`timescale 1ns/1ps
module ssc_half_sec #(
  parameter longint unsigned HALF_CYC = ssc_pkg::HALF_PERIOD_CYC
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  output logic wave_o
);

  // ********************************************************
  // Half-period counter
  // ********************************************************
  logic [31:0] cnt_r;
  localparam logic [31:0] LAST = 32'(HALF_CYC - 1);

  // Toggle on the last count so each level lasts exactly HALF_CYC edges
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r <= 32'h0000_0000;
      wave_o <= 1'b1;
    end
    else if (cnt_r == LAST)
    begin
      cnt_r <= 32'h0000_0000;
      wave_o <= ~wave_o;
    end
    else
    begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

endmodule : ssc_half_sec

// ---- rtl/ssc_pkg.sv ----
/*
  Shared constants for the system status and control flag block:
  register offsets, flag bit positions, reset values and timing.
  Assumes a 125 MHz controller clock and a 32-bit APB register bus.
*/
package ssc_pkg;

  // ********************************************************
  // Bus geometry
  // ********************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // ********************************************************
  // Register offsets (byte addresses)
  // ********************************************************
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_SCAN = 12'h008;

  // ********************************************************
  // Status register bit positions (flag number minus one)
  // ********************************************************
  localparam int unsigned ST_CONST_HIGH = 0;
  localparam int unsigned ST_CONST_LOW = 1;
  localparam int unsigned ST_HALF_SQUARE = 2;
  localparam int unsigned ST_CALENDAR_FAULT = 3;
  localparam int unsigned ST_DAYLIGHT = 4;
  localparam int unsigned ST_FB_COMM_FAULT = 5;
  localparam int unsigned ST_FB_POWER_FAULT = 6;
  localparam int unsigned ST_INIT_HIGH = 7;
  localparam int unsigned ST_INIT_LOW = 8;
  localparam int unsigned ST_TS_DECODING = 9;
  localparam int unsigned ST_TS_SUCCESS = 10;
  localparam int unsigned ST_MODEM_CARRIER = 11;
  localparam int unsigned ST_CELL_REG = 12;
  localparam int unsigned ST_TS_FAILURE = 14;
  localparam int unsigned ST_CONV_SUPPLY = 15;
  localparam int unsigned ST_ANALOG_BASE = 16;
  localparam int unsigned ANALOG_CH = 8;

  // ********************************************************
  // Control register bit positions and reset value
  // ********************************************************
  localparam int unsigned CT_FB_DISCONNECT = 0;
  localparam int unsigned CT_BL_INHIBIT = 1;
  localparam int unsigned CT_BL_FORCE = 2;
  localparam int unsigned CT_DISP_SOURCE = 3;
  localparam int unsigned CT_W = 4;
  localparam logic [CT_W-1:0] CT_RESET = 4'h0;

  // Scan register: writing this bit marks the end of one program scan
  localparam int unsigned SC_SCAN_END = 0;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam longint unsigned CLK_HZ = 125000000;
  localparam longint unsigned HALF_PERIOD_MS = 500;
  localparam longint unsigned HALF_PERIOD_CYC = CLK_HZ / 1000 * HALF_PERIOD_MS;

  localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h0000_0000;

  // Scan-aligned pulse sequencer states
  typedef enum logic [1:0] {SP_IDLE, SP_ARMED, SP_ACTIVE} ssc_scan_state_e;

endpackage : ssc_pkg

// ---- rtl/ssc_pulse_if.sv ----
/*
  Carrier between the flag block and one scan-aligned pulse stretcher.
  Assumes both ends run on the same controller clock.
*/
`timescale 1ns/1ps
interface ssc_pulse_if;

  logic trig;      // One-cycle event to be shown for one scan
  logic scan_end;  // One-cycle mark of a program scan boundary
  logic pulse;     // Flag level, true for exactly one scan

  modport src
  (
    output trig,
    output scan_end,
    input pulse
  );

  modport stretch
  (
    input trig,
    input scan_end,
    output pulse
  );

endinterface : ssc_pulse_if

// ---- rtl/ssc_scan_pulse.sv ----
/*
  Stretches a one-cycle event into a flag that lasts exactly one scan:
  the event arms, the next scan boundary shows the flag, the one after
  removes it. Assumes scan_end is a one-cycle mark from software.
*/
`timescale 1ns/1ps
module ssc_scan_pulse
(
  input wire logic clk_i,
  input wire logic rst_i,
  ssc_pulse_if.stretch pif
);

  // ********************************************************
  // Sequencer
  // ********************************************************
  ssc_pkg::ssc_scan_state_e state_r;
  ssc_pkg::ssc_scan_state_e state_nxt;
  logic pending_r;  // Event seen while already showing the flag

  // Next state; an event never gets lost while a scan is under way
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ssc_pkg::SP_IDLE:
        if (pif.trig)
          state_nxt = ssc_pkg::SP_ARMED;
      ssc_pkg::SP_ARMED:
        if (pif.scan_end)
          state_nxt = ssc_pkg::SP_ACTIVE;
      ssc_pkg::SP_ACTIVE:
        if (pif.scan_end)
          state_nxt = (pending_r || pif.trig) ? ssc_pkg::SP_ARMED : ssc_pkg::SP_IDLE;
      default:
        state_nxt = ssc_pkg::SP_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_r <= ssc_pkg::SP_IDLE;
    else
      state_r <= state_nxt;
  end

  // Remember an event that lands during the active scan; a scan end clears it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pending_r <= 1'b0;
    else if (state_r == ssc_pkg::SP_ACTIVE && pif.trig && !pif.scan_end)
      pending_r <= 1'b1;
    else if (pif.scan_end)
      pending_r <= 1'b0;
  end

  // Flag level follows the active state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pif.pulse <= 1'b0;
    else
      pif.pulse <= (state_nxt == ssc_pkg::SP_ACTIVE);
  end

endmodule : ssc_scan_pulse

// ---- rtl/ssc_top.sv ----
/*
  System status and control flag block of a small programmable
  controller, reached over APB. Status flags are read by the program
  as inputs; control flags written by the program steer the fieldbus
  connection, LCD backlight and display source.
  Assumes all inputs are synchronous to CLK_I and that software writes
  the scan register once at the end of every program scan.
*/
`timescale 1ns/1ps
module ssc_top #(
  parameter longint unsigned HALF_PERIOD_CYC = ssc_pkg::HALF_PERIOD_CYC
)
(
  input wire logic CLK_I,
  input wire logic RST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ssc_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [ssc_pkg::DATA_W-1:0] PWDATA_I,
  output logic [ssc_pkg::DATA_W-1:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Device condition inputs
  input wire logic RUN_MODE_I,
  input wire logic RTC_DATA_ERR_I,
  input wire logic SUMMER_TIME_I,
  input wire logic FB_COMM_ERR_I,
  input wire logic FB_POWER_ERR_I,
  input wire logic TS_DECODING_I,
  input wire logic TS_DONE_I,
  input wire logic TS_ERR_I,
  input wire logic MODEM_DCD_I,
  input wire logic CELL_REG_I,
  input wire logic CONV_SUPPLY_I,
  input wire logic [ssc_pkg::ANALOG_CH-1:0] ANALOG_WIRE_BREAK_I,
  input wire logic [ssc_pkg::ANALOG_CH-1:0] ANALOG_RANGE_ERR_I,
  input wire logic MENU_LIGHT_ON_I,
  // Device function controls
  output logic FB_DISCONNECT_O,
  output logic BACKLIGHT_ON_O,
  output logic DISPLAY_FROM_MANAGER_O
);

  // ********************************************************
  // Register map
  // ********************************************************
  // 0x000 status, read only; a write completes without error
  //   bit 0      constant one
  //   bit 1      constant zero
  //   bit 2      half-second square wave
  //   bit 3      calendar fault
  //   bit 4      daylight saving
  //   bit 5      fieldbus link fault
  //   bit 6      fieldbus power fault
  //   bit 7      initial pulse, normally low
  //   bit 8      initial pulse, normally high
  //   bit 9      time-signal decoding
  //   bit 10     time-signal success, one scan
  //   bit 11     modem carrier
  //   bit 12     cellular network reachable
  //   bit 13     reserved, reads zero
  //   bit 14     time-signal failure, held
  //   bit 15     converter supply present
  //   bits 23:16 analog faults, channel 1 in bit 16
  //   bits 31:24 reserved, read zero
  // 0x004 control, read and write, bits 3:0
  //   bit 0 fieldbus disconnect
  //   bit 1 backlight inhibit
  //   bit 2 backlight force
  //   bit 3 display source
  // 0x008 scan mark, write only
  //   a one in bit 0 marks the end of a program scan; reads zero
  // Any other address answers with an error and reads zero

  // ********************************************************
  // Declarations
  // ********************************************************
  logic [ssc_pkg::CT_W-1:0] control_r;
  logic [ssc_pkg::DATA_W-1:0] status_w;
  logic run_mode_d_r;
  logic scan_end_r;
  logic ts_failure_r;
  logic calendar_fault_r;
  logic daylight_r;
  logic fb_comm_r;
  logic fb_power_r;
  logic ts_decoding_r;
  logic carrier_r;
  logic cell_reg_r;
  logic conv_supply_r;
  logic [ssc_pkg::ANALOG_CH-1:0] analog_fault_r;
  logic half_square_w;
  logic apb_access;
  logic apb_commit;
  logic addr_hit;

  ssc_pulse_if init_if ();
  ssc_pulse_if succ_if ();

  // ********************************************************
  // APB handshake
  // ********************************************************
  // One wait state: the access phase sees PREADY on its second edge
  assign apb_access = PSEL_I && PENABLE_I && !PREADY_O;
  assign apb_commit = PSEL_I && PENABLE_I && PREADY_O;

  // Address decode, one branch per register
  always_comb
  begin
    if (PADDR_I == ssc_pkg::OFS_STATUS)
      addr_hit = 1'b1;
    else if (PADDR_I == ssc_pkg::OFS_CONTROL)
      addr_hit = 1'b1;
    else if (PADDR_I == ssc_pkg::OFS_SCAN)
      addr_hit = 1'b1;
    else
      addr_hit = 1'b0;
  end

  // Ready and error are raised together for exactly one cycle
  // A master that keeps PENABLE past completion gets a second ready two edges later:
  // the !PREADY_O term blocks a repeat only on the completing edge
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PREADY_O <= apb_access;
      PSLVERR_O <= apb_access && !addr_hit;
    end
  end

  // Read data captured at the edge that raises ready
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      PRDATA_O <= ssc_pkg::RDATA_IDLE;
    else if (apb_access && !PWRITE_I)
    begin
      if (PADDR_I == ssc_pkg::OFS_STATUS)
        PRDATA_O <= status_w;
      else if (PADDR_I == ssc_pkg::OFS_CONTROL)
        PRDATA_O <= {{(ssc_pkg::DATA_W-ssc_pkg::CT_W){1'b0}}, control_r};
      else
        PRDATA_O <= ssc_pkg::RDATA_IDLE;  // Scan register and holes read zero
    end
    else if (apb_commit)
      PRDATA_O <= ssc_pkg::RDATA_IDLE;
  end

  // ********************************************************
  // Control flags
  // ********************************************************
  // Program-written flags; written only on the completing edge
  // Bits above the control field are dropped and read back as zero
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      control_r <= ssc_pkg::CT_RESET;
    else if (apb_commit && PWRITE_I && PADDR_I == ssc_pkg::OFS_CONTROL)
      control_r <= PWDATA_I[ssc_pkg::CT_W-1:0];
  end

  // Scan boundary mark, one cycle wide
  // A write of zero to the scan register is accepted but marks nothing
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      scan_end_r <= 1'b0;
    else
      scan_end_r <= apb_commit && PWRITE_I && PADDR_I == ssc_pkg::OFS_SCAN
                    && PWDATA_I[ssc_pkg::SC_SCAN_END];
  end

  // Function steering, registered so every output comes from a flop
  // Trade-off: one extra edge of lag buys glitch-free function outputs
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      FB_DISCONNECT_O <= 1'b0;
      BACKLIGHT_ON_O <= 1'b0;
      DISPLAY_FROM_MANAGER_O <= 1'b0;
    end
    else
    begin
      FB_DISCONNECT_O <= control_r[ssc_pkg::CT_FB_DISCONNECT];
      // Force is tested first so it outranks inhibit
      if (control_r[ssc_pkg::CT_BL_FORCE])
        BACKLIGHT_ON_O <= 1'b1;
      else if (control_r[ssc_pkg::CT_BL_INHIBIT])
        BACKLIGHT_ON_O <= 1'b0;
      else
        BACKLIGHT_ON_O <= MENU_LIGHT_ON_I;
      DISPLAY_FROM_MANAGER_O <= control_r[ssc_pkg::CT_DISP_SOURCE];
    end
  end

  // ********************************************************
  // Status sources
  // ********************************************************
  // Square wave free-runs from reset; software may read it at any phase
  ssc_half_sec #(
    .HALF_CYC(HALF_PERIOD_CYC)
  ) u_half_sec
  (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .wave_o(half_square_w)
  );

  // Mode edge detector feeding the initial pulse stretcher
  // Limitation: run mode already high when reset ends counts as a
  // stop-to-run change, so the program also sees the pulse at power-up
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      run_mode_d_r <= 1'b0;
    else
      run_mode_d_r <= RUN_MODE_I;
  end

  assign init_if.trig = RUN_MODE_I && !run_mode_d_r;
  assign init_if.scan_end = scan_end_r;
  assign succ_if.trig = TS_DONE_I && !TS_ERR_I;
  assign succ_if.scan_end = scan_end_r;

  ssc_scan_pulse u_init_pulse
  (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pif(init_if.stretch)
  );

  // Success pulse also lasts one scan so the program cannot miss it
  ssc_scan_pulse u_succ_pulse
  (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .pif(succ_if.stretch)
  );

  // Failure flag holds until a later decode ends cleanly
  // A done pulse without error is the only way to clear it
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
      ts_failure_r <= 1'b0;
    else if (TS_DONE_I)
      ts_failure_r <= TS_ERR_I;
  end

  // Level conditions sampled once so the status word is all flops
  // No synchroniser: these inputs already live on CLK_I
  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      calendar_fault_r <= 1'b0;
      daylight_r <= 1'b0;
      fb_comm_r <= 1'b0;
      fb_power_r <= 1'b0;
      ts_decoding_r <= 1'b0;
      carrier_r <= 1'b0;
      cell_reg_r <= 1'b0;
      conv_supply_r <= 1'b0;
    end
    else
    begin
      calendar_fault_r <= RTC_DATA_ERR_I;
      daylight_r <= SUMMER_TIME_I;
      fb_comm_r <= FB_COMM_ERR_I;
      fb_power_r <= FB_POWER_ERR_I;
      ts_decoding_r <= TS_DECODING_I;
      carrier_r <= MODEM_DCD_I;
      cell_reg_r <= CELL_REG_I;
      conv_supply_r <= CONV_SUPPLY_I;
    end
  end

  // Per-channel analog fault: either cause raises the flag
  genvar ch;
  generate
    for (ch = 0; ch < ssc_pkg::ANALOG_CH; ch++)
    begin : g_analog
      always_ff @(posedge CLK_I)
      begin
        if (RST_I)
          analog_fault_r[ch] <= 1'b0;
        else
          analog_fault_r[ch] <= ANALOG_WIRE_BREAK_I[ch] || ANALOG_RANGE_ERR_I[ch];
      end
    end
  endgenerate

  // ********************************************************
  // Status word
  // ********************************************************
  // Bit 13 and bits above the analog group read as zero
  // Built from flops only, so a read never sees a half-updated word
  always_comb
  begin
    status_w = ssc_pkg::RDATA_IDLE;
    status_w[ssc_pkg::ST_CONST_HIGH] = 1'b1;
    status_w[ssc_pkg::ST_CONST_LOW] = 1'b0;
    status_w[ssc_pkg::ST_HALF_SQUARE] = half_square_w;
    status_w[ssc_pkg::ST_CALENDAR_FAULT] = calendar_fault_r;
    status_w[ssc_pkg::ST_DAYLIGHT] = daylight_r;
    status_w[ssc_pkg::ST_FB_COMM_FAULT] = fb_comm_r;
    status_w[ssc_pkg::ST_FB_POWER_FAULT] = fb_power_r;
    status_w[ssc_pkg::ST_INIT_HIGH] = init_if.pulse;
    status_w[ssc_pkg::ST_INIT_LOW] = ~init_if.pulse;
    status_w[ssc_pkg::ST_TS_DECODING] = ts_decoding_r;
    status_w[ssc_pkg::ST_TS_SUCCESS] = succ_if.pulse;
    status_w[ssc_pkg::ST_MODEM_CARRIER] = carrier_r;
    status_w[ssc_pkg::ST_CELL_REG] = cell_reg_r;
    status_w[ssc_pkg::ST_TS_FAILURE] = ts_failure_r;
    status_w[ssc_pkg::ST_CONV_SUPPLY] = conv_supply_r;
    status_w[ssc_pkg::ST_ANALOG_BASE +: ssc_pkg::ANALOG_CH] = analog_fault_r;
  end

endmodule : ssc_top
